//--- core/bsp_device.sv
// Device end: boot source walk, host download handshake and power control
`timescale 1ns/100ps
module bsp_device #(
  parameter int CORES = bsp_pkg::BSP_NUM_CORES,
  parameter int DIV = bsp_pkg::BSP_CLK_DIV
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  bsp_if.device port,
  input wire logic debug_strap_in_i,
  input wire logic card_boot_select_i,
  input wire logic card_present_detect_i,
  input wire logic power_down_n_i,
  input wire logic [15:0] rom_word0_i,
  input wire logic [15:0] rom_word1_i,
  input wire logic [7:0] serial_byte0_i,
  input wire logic [7:0] serial_byte1_i,
  input wire logic [CORES-1:0] core_stop_i,
  input wire logic clk_div_en_i,
  output logic [CORES-1:0] dsp_core_run_o,
  output logic control_cpu_rom_o,
  output logic osc_pll_en_o,
  output logic clk_tick_o,
  output bsp_pkg::bsp_src_e boot_src_o,
  output logic [15:0] boot_addr_o,
  output logic [7:0] card_sector_o,
  output logic fw_start_o,
  output logic [7:0] img_data_o,
  output logic img_valid_o,
  input wire logic img_ready_i,
  output logic [15:0] img_len_o
);
  import bsp_pkg::*;

  initial begin
    if (CORES < 1 || CORES > 8) $error("bsp_device: CORES out of range");
    if (DIV < 2 || DIV > 256) $error("bsp_device: DIV out of range");
  end

  typedef enum logic [3:0] {
    ST_BOOT, ST_STRAP, ST_ROM, ST_CARD, ST_CARD_WAIT, ST_SERIAL,
    ST_HS1, ST_LEN_LO, ST_LEN_HI, ST_IMAGE, ST_HS2, ST_RUN, ST_DEBUG
  } bsp_st_e;

  typedef struct packed {
    bsp_st_e st;
    logic [2:0] rd_sync;
    logic [2:0] wr_sync;
    logic [1:0] strap_sync;
    logic [1:0] sel_sync;
    logic [1:0] pres_sync;
    logic [1:0] pdn_sync;
    logic [2:0] cs_sync;
    logic a0_q;
    logic [7:0] hdat_q;
    logic [7:0] tx_byte;
    logic tx_empty_flag;
    logic rx_full_flag;
    logic [7:0] rx_byte;
    logic [15:0] len;
    logic [16:0] bytes_left;
    logic [1:0] buf_cnt;
    logic [15:0] buf_q;
    logic [7:0] div_cnt;
    logic tick;
    logic [CORES-1:0] run;
    logic rom_exec;
    logic osc_en;
    bsp_src_e src;
    logic [15:0] addr;
    logic [7:0] sector;
    logic start;
    logic [7:0] dout;
    logic doe;
    logic irq;
  } bsp_dev_s;

  bsp_dev_s state_r, state_nxt;

  // Two bytes compare against the boot signature
  function automatic logic sig_ok(input logic [7:0] b0, input logic [7:0] b1);
    sig_ok = (b0 == BSP_SIG_LO) && (b1 == BSP_SIG_HI);
  endfunction : sig_ok

  logic rd_fall, wr_rise, img_pop;
  // Edge detects read only synced stages, never the first flop
  assign rd_fall = state_r.rd_sync[2] & ~state_r.rd_sync[1];
  assign wr_rise = ~state_r.wr_sync[2] & state_r.wr_sync[1];
  assign img_pop = state_r.buf_cnt != 2'd0 && img_ready_i;

  // Next state of the whole device
  always_comb begin
    state_nxt = state_r;
    state_nxt.rd_sync = {state_r.rd_sync[1:0], port.rd_n};
    state_nxt.wr_sync = {state_r.wr_sync[1:0], port.wr_n};
    state_nxt.strap_sync = {state_r.strap_sync[0], debug_strap_in_i};
    state_nxt.sel_sync = {state_r.sel_sync[0], card_boot_select_i};
    state_nxt.pres_sync = {state_r.pres_sync[0], card_present_detect_i};
    state_nxt.pdn_sync = {state_r.pdn_sync[0], power_down_n_i};
    // Select rides its own chain so it lines up with the strobe stages
    state_nxt.cs_sync = {state_r.cs_sync[1:0], port.cs_n};
    // Address and data stay put between strobes; one flop is enough
    state_nxt.a0_q = port.host_reg_select;
    state_nxt.hdat_q = port.host_data;
    state_nxt.start = 1'b0;
    state_nxt.osc_en = state_r.pdn_sync[1];
    state_nxt.div_cnt = state_r.div_cnt + 8'd1;
    state_nxt.tick = !clk_div_en_i || state_r.div_cnt == 8'(DIV - 1);
    if (state_r.div_cnt == 8'(DIV - 1)) begin
      state_nxt.div_cnt = 8'd0;
    end
    if (state_r.st == ST_RUN) begin
      state_nxt.run = ~core_stop_i;
    end
    // Host read path: drive data while selected and reading
    state_nxt.doe = !state_r.cs_sync[2] && !state_r.rd_sync[2];
    state_nxt.dout = 8'h00;
    if (state_r.a0_q) begin
      state_nxt.dout[BSP_STAT_TE_BIT] = state_r.tx_empty_flag;
      state_nxt.dout[BSP_STAT_RF_BIT] = state_r.rx_full_flag;
    end else begin
      state_nxt.dout = state_r.tx_byte;
    end
    if (rd_fall && !state_r.cs_sync[1] && !state_r.a0_q) begin
      state_nxt.tx_empty_flag = 1'b1;
      state_nxt.irq = 1'b0;
    end
    // Host write fills receiver; a full receiver drops the byte
    // Select taken beside the low strobe: a host may lift both at once
    if (wr_rise && !state_r.cs_sync[2] && !state_r.rx_full_flag) begin
      state_nxt.rx_byte = state_r.hdat_q;
      state_nxt.rx_full_flag = 1'b1;
    end
    // Drain side of two-entry buffer
    if (img_pop) begin
      state_nxt.buf_cnt = state_r.buf_cnt - 2'd1;
      state_nxt.buf_q = {8'h00, state_r.buf_q[15:8]};
    end
    // Boot walk
    unique case (state_r.st)
      ST_BOOT: begin
        state_nxt.run = '0;
        state_nxt.rom_exec = 1'b1;
        state_nxt.st = ST_STRAP;
      end
      ST_STRAP: begin
        if (state_r.strap_sync[1]) begin
          state_nxt.src = BSP_SRC_DEBUG;
          state_nxt.st = ST_DEBUG;
        end else begin
          state_nxt.st = ST_ROM;
        end
      end
      ST_ROM: begin
        if (sig_ok(rom_word0_i[7:0], rom_word1_i[7:0])) begin
          state_nxt.src = BSP_SRC_ROM;
          state_nxt.addr = BSP_ROM_JUMP;
          state_nxt.rom_exec = 1'b0;
          state_nxt.start = 1'b1;
          state_nxt.st = ST_RUN;
        end else begin
          state_nxt.st = ST_CARD;
        end
      end
      ST_CARD: begin
        state_nxt.st = state_r.sel_sync[1] ? ST_SERIAL : ST_CARD_WAIT;
      end
      ST_CARD_WAIT: begin
        if (state_r.pres_sync[1]) begin
          state_nxt.src = BSP_SRC_CARD;
          state_nxt.sector = BSP_CARD_SECTOR;
          state_nxt.rom_exec = 1'b0;
          state_nxt.start = 1'b1;
          state_nxt.st = ST_RUN;
        end
      end
      ST_SERIAL: begin
        if (sig_ok(serial_byte0_i, serial_byte1_i)) begin
          state_nxt.src = BSP_SRC_SERIAL;
          state_nxt.rom_exec = 1'b0;
          state_nxt.start = 1'b1;
          state_nxt.st = ST_RUN;
        end else begin
          state_nxt.src = BSP_SRC_HOST;
          state_nxt.st = ST_HS1;
        end
      end
      ST_HS1: begin
        state_nxt.tx_byte = BSP_HANDSHAKE;
        state_nxt.tx_empty_flag = 1'b0;
        state_nxt.irq = 1'b1;
        state_nxt.st = ST_LEN_LO;
      end
      ST_LEN_LO: begin
        if (state_r.rx_full_flag) begin
          state_nxt.len[7:0] = state_r.rx_byte;
          state_nxt.rx_full_flag = 1'b0;
          state_nxt.st = ST_LEN_HI;
        end
      end
      ST_LEN_HI: begin
        if (state_r.rx_full_flag) begin
          state_nxt.len[15:8] = state_r.rx_byte;
          state_nxt.bytes_left = {state_r.rx_byte, state_r.len[7:0], 1'b0};
          state_nxt.rx_full_flag = 1'b0;
          state_nxt.st = ST_IMAGE;
        end
      end
      ST_IMAGE: begin
        if (state_r.bytes_left == 17'd0) begin
          state_nxt.st = ST_HS2;
        end else if (state_r.rx_full_flag && state_nxt.buf_cnt != 2'd2) begin
          // Receiver held full until buffer has room: host sees stall
          state_nxt.buf_q[8 * state_nxt.buf_cnt[0] +: 8] = state_r.rx_byte;
          state_nxt.buf_cnt = state_nxt.buf_cnt + 2'd1;
          state_nxt.rx_full_flag = 1'b0;
          state_nxt.bytes_left = state_r.bytes_left - 17'd1;
        end
      end
      ST_HS2: begin
        if (state_r.buf_cnt == 2'd0) begin
          state_nxt.tx_byte = BSP_HANDSHAKE;
          state_nxt.tx_empty_flag = 1'b0;
          state_nxt.irq = 1'b1;
          state_nxt.rom_exec = 1'b0;
          state_nxt.start = 1'b1;
          state_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      ST_DEBUG: begin
      end
      default: state_nxt.st = ST_BOOT;
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= '0;
      // Pin syncs keep sampling in reset so straps are settled at release
      state_r.strap_sync <= state_nxt.strap_sync;
      state_r.sel_sync <= state_nxt.sel_sync;
      state_r.pres_sync <= state_nxt.pres_sync;
      state_r.pdn_sync <= state_nxt.pdn_sync;
      state_r.st <= ST_BOOT;
      state_r.rd_sync <= 3'b111;
      state_r.wr_sync <= 3'b111;
      state_r.cs_sync <= 3'b111;
      state_r.tx_empty_flag <= 1'b1;
      state_r.osc_en <= 1'b1;
      state_r.rom_exec <= 1'b1;
      state_r.src <= BSP_SRC_NONE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  assign dsp_core_run_o = state_r.run;
  assign control_cpu_rom_o = state_r.rom_exec;
  assign osc_pll_en_o = state_r.osc_en;
  assign clk_tick_o = state_r.tick;
  assign boot_src_o = state_r.src;
  assign boot_addr_o = state_r.addr;
  assign card_sector_o = state_r.sector;
  assign fw_start_o = state_r.start;
  assign img_data_o = state_r.buf_q[7:0];
  assign img_valid_o = state_r.buf_cnt != 2'd0;
  assign img_len_o = state_r.len;
  assign port.dev_data = state_r.dout;
  assign port.dev_data_oe = state_r.doe;
  assign port.irq = state_r.irq;
endmodule : bsp_device

//--- include/bsp_pkg.sv
// Package with constants and types shared by both ends of the boot link
package bsp_pkg;
  localparam logic [7:0] BSP_HANDSHAKE = 8'hAC;
  localparam logic [7:0] BSP_SIG_LO = 8'h5A;  // Signature byte 0, arbitrary
  localparam logic [7:0] BSP_SIG_HI = 8'hA5;  // Signature byte 1, arbitrary
  localparam logic [15:0] BSP_ROM_JUMP = 16'h0400;
  localparam logic [7:0] BSP_CARD_SECTOR = 8'h01;
  localparam int BSP_STAT_TE_BIT = 7;
  localparam int BSP_STAT_RF_BIT = 6;
  localparam int BSP_CLK_DIV = 256;
  localparam int BSP_CLK_HZ = 50_000_000;
  localparam int BSP_SETTLE_MS = 10;
  localparam int BSP_SETTLE_CYC = BSP_SETTLE_MS * (BSP_CLK_HZ / 1000);
  localparam int BSP_WR_GAP_US = 3;
  localparam int BSP_WR_GAP_CYC = BSP_WR_GAP_US * (BSP_CLK_HZ / 1_000_000);
  localparam int BSP_NUM_CORES = 3;
  // Boot source that won
  typedef enum logic [2:0] {
    BSP_SRC_NONE,
    BSP_SRC_DEBUG,
    BSP_SRC_ROM,
    BSP_SRC_CARD,
    BSP_SRC_SERIAL,
    BSP_SRC_HOST
  } bsp_src_e;
endpackage : bsp_pkg

//--- include/bsp_if.sv
// Interface carrying the 8-bit slave parallel port between host and device
`timescale 1ns/100ps
interface bsp_if;
  logic cs_n;
  logic host_reg_select;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_data;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic irq;
  modport device (
    input cs_n, host_reg_select, rd_n, wr_n, host_data,
    output dev_data, dev_data_oe, irq
  );
  modport host (
    output cs_n, host_reg_select, rd_n, wr_n, host_data,
    input dev_data, dev_data_oe, irq
  );
endinterface : bsp_if

//--- core/bsp_host.sv
// Host end: waits for handshake, sends length and image, waits for acknowledge
`timescale 1ns/100ps
module bsp_host #(
  parameter int GAP = bsp_pkg::BSP_WR_GAP_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  bsp_if.host port,
  input wire logic [15:0] len_words_i,
  input wire logic go_i,
  input wire logic [7:0] img_data_i,
  input wire logic img_valid_i,
  output logic img_ready_o,
  output logic done_o,
  output logic error_o
);
  import bsp_pkg::*;

  initial begin
    if (GAP < 8 || GAP > 65535) $error("bsp_host: GAP out of range");
  end

  typedef enum logic [2:0] {
    HS_IDLE, HS_WAIT1, HS_READ, HS_SEND, HS_POLL, HS_STROBE, HS_WAIT2, HS_DONE
  } bsp_hst_e;

  typedef struct packed {
    bsp_hst_e st;
    logic [1:0] irq_sync;
    logic ack;
    logic [1:0] phase;
    logic [16:0] left;
    logic [7:0] hold;
    logic [15:0] gap;
    logic cs_n;
    logic a0;
    logic rd_n;
    logic wr_n;
    logic [7:0] dat;
    logic rdy;
    logic done;
    logic err;
  } bsp_hst_s;

  bsp_hst_s state_r, state_nxt;

  // Host sequence
  always_comb begin
    state_nxt = state_r;
    state_nxt.irq_sync = {state_r.irq_sync[0], port.irq};
    state_nxt.rdy = 1'b0;
    if (state_r.gap != 16'd0) begin
      state_nxt.gap = state_r.gap - 16'd1;
    end
    unique case (state_r.st)
      HS_IDLE: begin
        if (go_i) begin
          state_nxt.left = {len_words_i, 1'b0} + 17'd2;
          state_nxt.phase = 2'd0;
          state_nxt.st = HS_WAIT1;
        end
      end
      HS_WAIT1, HS_WAIT2: begin
        if (state_r.irq_sync[1]) begin
          state_nxt.cs_n = 1'b0;
          state_nxt.a0 = 1'b0;
          state_nxt.rd_n = 1'b0;
          state_nxt.gap = 16'(GAP);
          state_nxt.ack = state_r.st == HS_WAIT2;
          state_nxt.st = HS_READ;
        end
      end
      // Read strobe held a full gap so the device sees it and irq falls
      HS_READ: begin
        if (state_r.gap == 16'd0) begin
          state_nxt.cs_n = 1'b1;
          state_nxt.rd_n = 1'b1;
          state_nxt.err = port.dev_data != BSP_HANDSHAKE;
          state_nxt.st = state_r.ack ? HS_DONE : HS_SEND;
        end
      end
      HS_SEND: begin
        if (state_r.left == 17'd0) begin
          state_nxt.st = HS_WAIT2;
        end else if (state_r.gap == 16'd0) begin
          if (state_r.phase != 2'd2) begin
            state_nxt.hold = state_r.phase == 2'd0 ? len_words_i[7:0] : len_words_i[15:8];
            state_nxt.phase = state_r.phase + 2'd1;
            state_nxt.st = HS_POLL;
          end else if (img_valid_i) begin
            state_nxt.hold = img_data_i;
            state_nxt.rdy = 1'b1;
            state_nxt.st = HS_POLL;
          end
        end
      end
      HS_POLL: begin
        if (state_r.gap == 16'd0) begin
          // Open a status read, then close it and judge the receiver bit
          state_nxt.cs_n = !state_r.rd_n;
          state_nxt.a0 = state_r.rd_n;
          state_nxt.rd_n = !state_r.rd_n;
          state_nxt.gap = 16'(GAP);
          // A stalled device keeps receiver full; writing then loses the byte
          if (!state_r.rd_n && !port.dev_data[BSP_STAT_RF_BIT]) begin
            state_nxt.st = HS_STROBE;
          end
        end
      end
      HS_STROBE: begin
        state_nxt.cs_n = 1'b0;
        state_nxt.wr_n = ~state_r.wr_n;
        state_nxt.dat = state_r.hold;
        if (!state_r.wr_n) begin
          state_nxt.cs_n = 1'b1;
          state_nxt.left = state_r.left - 17'd1;
          state_nxt.gap = 16'(GAP);
          state_nxt.st = HS_SEND;
        end
      end
      HS_DONE: begin
        state_nxt.done = 1'b1;
      end
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= '0;
      state_r.st <= HS_IDLE;
      state_r.cs_n <= 1'b1;
      state_r.rd_n <= 1'b1;
      state_r.wr_n <= 1'b1;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  assign img_ready_o = state_r.rdy;
  assign done_o = state_r.done;
  assign error_o = state_r.err;
  assign port.cs_n = state_r.cs_n;
  assign port.host_reg_select = state_r.a0;
  assign port.rd_n = state_r.rd_n;
  assign port.wr_n = state_r.wr_n;
  assign port.host_data = state_r.dat;
endmodule : bsp_host

//--- tb/bsp_link_monitor.sv
// Checker for the parallel port joining the host and device ends
`timescale 1ns/100ps
module bsp_link_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n,
  input wire logic host_reg_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] host_data,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic irq
);
  import bsp_pkg::*;
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Port is quiet on the first edge out of reset
  property p_reset_quiet;
    $fell(reset_i) |-> !irq && !dev_data_oe && cs_n;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("port busy after reset");
  // Host strobes only with the chip selected
  property p_strobe_select;
    !rd_n || !wr_n |-> !cs_n;
  endproperty
  a_strobe_select: assert property (p_strobe_select) else $error("strobe without select");
  // Read answered once the strobe crosses the sync chain
  property p_oe_answer;
    $fell(rd_n) && !cs_n |-> ##[1:6] dev_data_oe;
  endproperty
  a_oe_answer: assert property (p_oe_answer) else $error("read not answered");
  // Status bit 7 is the inverse of the interrupt while the host polls
  property p_status_te;
    dev_data_oe && host_reg_select && $stable(irq) |-> dev_data[BSP_STAT_TE_BIT] == !irq;
  endproperty
  a_status_te: assert property (p_status_te) else $error("status bit 7 wrong");
  // Handshake is the only data byte ever sent to the host
  property p_data_is_hs;
    dev_data_oe && !cs_n && !rd_n && !host_reg_select |-> dev_data == BSP_HANDSHAKE;
  endproperty
  a_data_is_hs: assert property (p_data_is_hs) else $error("data byte not handshake");
  // Interrupt stands while no read is made
  property p_irq_holds;
    (irq && rd_n) [*6] |=> irq;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped unread");
  // A data read drops the interrupt within a bounded time
  property p_irq_clears;
    irq && !cs_n && !rd_n && !host_reg_select |-> ##[1:8] !irq;
  endproperty
  a_irq_clears: assert property (p_irq_clears) else $error("irq kept after read");
  // Host leaves a gap after every write strobe
  property p_write_gap;
    $rose(wr_n) |-> wr_n [*4];
  endproperty
  a_write_gap: assert property (p_write_gap) else $error("writes too close");
endmodule : bsp_link_monitor

//--- tb/boot_sequencer_power_control_tb.sv
// Bench joining host and device ends, driving both user sides
`timescale 1ns/100ps
module boot_sequencer_power_control_tb;
  import bsp_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
  logic debug_strap_in_i = 1'b0, card_boot_select_i = 1'b1, card_present_detect_i = 1'b0;
  logic power_down_n_i = 1'b1, clk_div_en_i = 1'b0, img_ready_i = 1'b0, go_i = 1'b0;
  logic img_valid_i = 1'b0;
  logic [15:0] rom_word0_i = 16'h0000, rom_word1_i = {8'h00, BSP_SIG_HI}, len_words_i = 16'h0000;
  logic [7:0] serial_byte0_i = 8'h00, serial_byte1_i = BSP_SIG_HI, img_data_i = 8'h00;
  logic [BSP_NUM_CORES-1:0] core_stop_i = '0, dsp_core_run_o;
  logic control_cpu_rom_o, osc_pll_en_o, clk_tick_o, fw_start_o, img_valid_o;
  logic img_ready_o, done_o, error_o;
  logic [15:0] boot_addr_o, img_len_o;
  logic [7:0] card_sector_o, img_data_o;
  bsp_src_e boot_src_o;
  logic [7:0] got_q[$];
  int bad_count = 0, samples_checked = 0, starts = 0;
  bsp_if link ();
  // Both ends face each other; host polls status, so a short gap is safe
  bsp_device bsp_device_inst (.clk_i, .reset_i, .ce_i, .port(link), .debug_strap_in_i,
    .card_boot_select_i, .card_present_detect_i, .power_down_n_i, .rom_word0_i, .rom_word1_i,
    .serial_byte0_i, .serial_byte1_i, .core_stop_i, .clk_div_en_i, .dsp_core_run_o,
    .control_cpu_rom_o, .osc_pll_en_o, .clk_tick_o, .boot_src_o, .boot_addr_o, .card_sector_o,
    .fw_start_o, .img_data_o, .img_valid_o, .img_ready_i, .img_len_o);
  bsp_host #(.GAP(8)) bsp_host_inst (.clk_i, .reset_i, .ce_i, .port(link), .len_words_i, .go_i,
    .img_data_i, .img_valid_i, .img_ready_o, .done_o, .error_o);
  bsp_link_monitor bsp_link_monitor_inst (.clk_i, .reset_i, .cs_n(link.cs_n),
    .host_reg_select(link.host_reg_select), .rd_n(link.rd_n), .wr_n(link.wr_n),
    .host_data(link.host_data), .dev_data(link.dev_data), .dev_data_oe(link.dev_data_oe),
    .irq(link.irq));
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  // Collect bytes leaving the device and count start pulses
  always @(posedge clk_i) begin
    if (img_valid_o === 1'b1 && img_ready_i === 1'b1) got_q.push_back(img_data_o);
    if (fw_start_o === 1'b1) starts++;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cycles
  // Straps are set before reset so the sync flops hold them at release
  task automatic boot_to(input logic s, input logic c, input logic [15:0] r, input logic [7:0] e);
    debug_strap_in_i = s;
    card_boot_select_i = c;
    rom_word0_i = r;
    serial_byte0_i = e;
    reset_i = 1'b1;
    cycles(10);
    check(16'(dsp_core_run_o), 16'h0000);
    check(16'(control_cpu_rom_o), 16'h0001);
    reset_i = 1'b0;
  endtask : boot_to
  task automatic expect_src(input bsp_src_e want);
    for (int i = 0; i < 80 && boot_src_o !== want; i++) cycles(1);
    check(16'(boot_src_o), 16'(want));
  endtask : expect_src
  // Strap beats a good ROM, ROM beats the card, a bad low byte falls through
  task automatic t_order;
    boot_to(1'b1, 1'b0, {8'h00, BSP_SIG_LO}, BSP_SIG_LO);
    expect_src(BSP_SRC_DEBUG);
    boot_to(1'b0, 1'b0, {8'h00, BSP_SIG_LO}, BSP_SIG_LO);
    expect_src(BSP_SRC_ROM);
    check(boot_addr_o, BSP_ROM_JUMP);
    check(16'(control_cpu_rom_o), 16'h0000);
    boot_to(1'b0, 1'b1, {BSP_SIG_LO, 8'h00}, BSP_SIG_LO);
    expect_src(BSP_SRC_SERIAL);
  endtask : t_order
  // Card boot must wait for presence even with a good serial memory
  task automatic t_card;
    card_present_detect_i = 1'b0;
    boot_to(1'b0, 1'b0, 16'h0000, BSP_SIG_LO);
    cycles(60);
    check(16'(boot_src_o == BSP_SRC_CARD || boot_src_o == BSP_SRC_SERIAL), 16'h0000);
    card_present_detect_i = 1'b1;
    expect_src(BSP_SRC_CARD);
    check(16'(card_sector_o), 16'(BSP_CARD_SECTOR));
    card_present_detect_i = 1'b0;
  endtask : t_card
  // Host download while the image sink stalls long enough to fill the buffer
  task automatic t_host;
    logic [7:0] img[4] = '{BSP_SIG_LO, BSP_SIG_HI, 8'h3C, 8'hE1};
    int n;
    boot_to(1'b0, 1'b1, 16'h0000, 8'h00);
    expect_src(BSP_SRC_HOST);
    got_q.delete();
    starts = 0;
    len_words_i = 16'h0002;
    go_i = 1'b1;
    fork
      begin
        cycles(300);
        img_ready_i = 1'b1;
      end
    join_none
    foreach (img[i]) begin
      img_data_i = img[i];
      img_valid_i = 1'b1;
      n = 0;
      do cycles(1); while (img_ready_o !== 1'b1 && ++n < 3000);
    end
    img_valid_i = 1'b0;
    for (n = 0; n < 3000 && done_o !== 1'b1; n++) cycles(1);
    cycles(20);
    check(16'(done_o), 16'h0001);
    check(16'(error_o), 16'h0000);
    check(16'(starts), 16'h0001);
    check(img_len_o, 16'h0002);
    check(16'(got_q.size()), 16'h0004);
    foreach (img[i]) check(16'(got_q[i]), 16'(img[i]));
    go_i = 1'b0;
    // One core stopped alone, the others keep running
    core_stop_i = 3'h2;
    cycles(6);
    check(16'(dsp_core_run_o), 16'h0005);
    core_stop_i = '0;
  endtask : t_host
  // Count ticks over 512 cycles, undivided and divided
  task automatic t_clock;
    int k;
    for (int d = 0; d < 2; d++) begin
      clk_div_en_i = d[0];
      cycles(8);
      k = 0;
      repeat (512) begin
        cycles(1);
        if (tick_hit()) k++;
      end
      check(16'(k), d ? 16'(512 / BSP_CLK_DIV) : 16'h0200);
    end
    clk_div_en_i = 1'b0;
  endtask : t_clock
  function automatic bit tick_hit();
    return clk_tick_o === 1'b1;
  endfunction : tick_hit
  // Power-down stops the clocks; the pin is raised, then reset restarts them and reboots
  task automatic t_power;
    power_down_n_i = 1'b0;
    cycles(6);
    check(16'(osc_pll_en_o), 16'h0000);
    power_down_n_i = 1'b1;
    cycles(2);
    boot_to(1'b0, 1'b1, 16'h0000, BSP_SIG_LO);
    check(16'(osc_pll_en_o), 16'h0001);
    expect_src(BSP_SRC_SERIAL);
  endtask : t_power
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    t_order();
    t_card();
    t_host();
    t_clock();
    t_power();
    tally_and_finish();
  end
  // Watchdog well past the longest bounded waits
  initial begin
    cycles(30000);
    bad_count++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end
endmodule : boot_sequencer_power_control_tb
